// >>> dma_addr_step.sv
// Post-transfer address update for one channel.
// Only the low 24 bits count; the upper byte is carried through untouched.
`timescale 1ns/100ps
`default_nettype none
module dma_addr_step
   import micro_dma_pkg::*;
(
   // Current channel state
   input wire logic [7:0] mode_in,
   input wire logic [31:0] src_in,
   input wire logic [31:0] dst_in,
   // Updated addresses
   output logic [31:0] src_out,
   output logic [31:0] dst_out
);
   logic [2:0] mode;
   logic [23:0] step;

   assign mode = mode_in[MODE_LSB +: 3];
   assign step = 24'h00_0001 << mode_in[SIZE_LSB +: 2];

   always_comb
   begin
      src_out = src_in;
      dst_out = dst_in;
      case (mode)
         M_DST_INC: dst_out[23:0] = dst_in[23:0] + step;
         M_DST_DEC: dst_out[23:0] = dst_in[23:0] - step;
         M_SRC_INC: src_out[23:0] = src_in[23:0] + step;
         M_SRC_DEC: src_out[23:0] = src_in[23:0] - step;
         M_COUNTER: src_out[23:0] = src_in[23:0] + 24'h00_0001;
         default: ;
      endcase
   end
endmodule
`default_nettype wire

// >>> dma_chan_arbiter.sv
// Fixed-priority pick among pending channels.
// Pending bits arrive ungated; the caller applies the mask and halt conditions to the request.
`timescale 1ns/100ps
`default_nettype none
module dma_chan_arbiter
   import micro_dma_pkg::*;
#(
   parameter int N = CHANNELS
)
(
   // Requests
   input wire logic [N-1:0] pend_in,
   // Choice
   output logic any_out,
   output logic [1:0] idx_out
);
   initial
   begin
      if (N < 1 || N > 4)
         $error("dma_chan_arbiter: N must be 1 to 4");
   end

   // Scan from the top so the lowest channel wins.
   always_comb
   begin
      any_out = |pend_in;
      idx_out = 2'h0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (pend_in[i])
            idx_out = 2'(i);
      end
   end
endmodule
`default_nettype wire

// >>> dma_partner.sv
// Far side of the engine: memory bus and source request flags.
// Assumes the engine drives its bus request combinationally.
`timescale 1ns/100ps
`default_nettype none
module dma_partner
   import micro_dma_pkg::*;
(
   // Clock, reset and engine side
   input wire logic clock_in,
   input wire logic rst_in,
   input wire mem_req_t req_in,
   input wire logic [SOURCES-1:0] clr_in,
   input wire logic [SOURCES-1:0] raise_in,
   // Answers and what was seen
   output logic [31:0] rdata_out,
   output logic [SOURCES-1:0] flag_out,
   output logic [23:0] waddr_out,
   output logic [31:0] wdata_out,
   output logic [15:0] writes_out
);
   logic wr_q;
   // An idle bus shows the inverse, so a stale sample cannot match.
   assign rdata_out = {8'h5A, req_in.addr} ^ {32{!req_in.rd}};
   always_ff @(posedge clock_in or posedge rst_in)
      if (rst_in)
         {flag_out, writes_out, wr_q, waddr_out, wdata_out} <= '0;
      else
      begin
         flag_out <= (flag_out & ~clr_in) | raise_in;
         wr_q <= req_in.wr;
         if (req_in.wr && !wr_q)
            {writes_out, waddr_out, wdata_out} <=
               {writes_out + 16'h0001, req_in.addr, req_in.wdata};
      end
endmodule
`default_nettype wire

// >>> micro_dma.sv
// Four-channel interrupt-triggered micro DMA engine with AXI4-Lite registers.
// Assumes the interrupt controller supplies request flags and takes clears.
// Contract
// - DMA service runs at maskable level six
// - No service while CPU mask level is seven
// - Requests stay pending while CPU halted
// - Four channels; accepting clears source request flag
// - Move one item, then decrement count
// - Count zero: end interrupt, clear start vector
// - Nonzero count without burst: finish quietly
// - Cleared vector leaves source to ordinary interrupts
// - Simultaneous requests: lowest channel number wins
// - Addresses use low 24 bits only
// - Addresses step up, down or stay
// - Sixteen-bit count; zero means 65536 services
// - Thirty interrupt sources plus software start
// - Word transfer: fetch, read, gap, write states
// - Narrow or odd area adds two states
// - Writing one starts service; zero does nothing
// - Software request bit clears at transfer end
// - Burst repeats transfers until count reaches zero
// - Software start during service leaves count alone
// - End interrupts prioritised by interrupt controller
// - Mode byte: mode field and size field
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module micro_dma
   import micro_dma_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt controller and CPU
   input wire logic [SOURCES-1:0] irq_flag_in,
   input wire logic [2:0] cpu_interrupt_mask_level_in,
   input wire logic cpu_halted_in,
   input wire logic queue_full_in,
   output logic [SOURCES-1:0] irq_clear_out,
   output logic [CHANNELS-1:0] transfer_end_interrupt_out,
   output logic dma_request_out,
   output logic [2:0] dma_level_out,
   // Memory bus
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_area8_in,
   output mem_req_t mem_req_out,
   output logic fetch_out
);
   ////////////////////////////////////////////////////////////////////////
   chan_regs_t ch_reg [CHANNELS];
   logic [CHANNELS-1:0] software_start_register_reg;
   logic [CHANNELS-1:0] burst_select_register_reg;
   seq_state_t state_reg;
   logic [2:0] cyc_reg;
   logic [1:0] act_reg;
   logic [31:0] data_reg;
   logic [CHANNELS-1:0] pend;
   logic allowed, any_pend, stretch, phase_last;
   logic [1:0] pick;
   logic [31:0] src_next, dst_next;
   logic [15:0] cnt_next;
   logic continue_burst;
   chan_regs_t act;
   logic wr_go, bus_ok;
   logic [31:0] wmask;

   assign act = ch_reg[act_reg];

   // A low five-bit vector code of 0 or above the source count means no start source.
   generate
      for (genvar c = 0; c < CHANNELS; c++)
      begin : g_pend
         logic [VEC_W-1:0] v;
         logic hit;
         assign v = ch_reg[c].vec[VEC_W-1:0];
         assign hit = (v != '0) && (32'(v) <= SOURCES)
                      && irq_flag_in[VEC_W'(v - VEC_W'(1))];
         assign pend[c] = hit || software_start_register_reg[c];
      end
   endgenerate

   assign allowed = (cpu_interrupt_mask_level_in != MASK_BLOCK)
                    && !cpu_halted_in;
   assign dma_request_out = allowed && any_pend && state_reg == S_IDLE;
   assign dma_level_out = DMA_LEVEL;

   dma_chan_arbiter #(.N(CHANNELS)) u_arb (
      .pend_in(pend),
      .any_out(any_pend),
      .idx_out(pick)
   );

   dma_addr_step u_step (
      .mode_in(act.mode),
      .src_in(act.src),
      .dst_in(act.dst),
      .src_out(src_next),
      .dst_out(dst_next)
   );

   // Zero wraps to all ones, so a zero start gives 65536 services.
   assign cnt_next = act.cnt - 16'h0001;
   assign continue_burst = burst_select_register_reg[act_reg]
                           && cnt_next != RST_CNT;

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer.
   assign stretch = mem_area8_in || (mem_req_out.addr[0]
                    && mem_req_out.size != SZ_BYTE);
   assign phase_last = cyc_reg == (stretch ? ST_BUS + ST_STRETCH - 3'h1
                                           : ST_BUS - 3'h1);

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= S_IDLE;
         cyc_reg <= 3'h0;
         act_reg <= 2'h0;
      end
      else
      begin
         cyc_reg <= cyc_reg + 3'h1;
         case (state_reg)
            S_IDLE:
            begin
               cyc_reg <= 3'h0;
               if (dma_request_out)
               begin
                  act_reg <= pick;
                  state_reg <= S_FETCH;
               end
            end
            S_FETCH:
               if (cyc_reg == ST_FETCH - 3'h1)
               begin
                  cyc_reg <= 3'h0;
                  state_reg <= (act.mode[MODE_LSB +: 3] == M_COUNTER)
                               ? S_COUNT : S_READ;
               end
            S_READ:
               if (phase_last)
               begin
                  cyc_reg <= 3'h0;
                  state_reg <= S_GAP;
               end
            S_GAP:
            begin
               cyc_reg <= 3'h0;
               state_reg <= S_WRITE;
            end
            S_WRITE:
               if (phase_last)
                  state_reg <= S_DONE;
            S_COUNT:
               if (cyc_reg == ST_COUNTER - 3'h1)
                  state_reg <= S_DONE;
            S_DONE:
            begin
               cyc_reg <= 3'h0;
               state_reg <= continue_burst ? S_FETCH : S_IDLE;
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   // Read data is captured on the last read state.
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         data_reg <= 32'h0000_0000;
      else if (state_reg == S_READ && phase_last)
         data_reg <= mem_rdata_in;
   end

   always_comb
   begin
      mem_req_out = '0;
      mem_req_out.size = act.mode[SIZE_LSB +: 2];
      mem_req_out.wdata = data_reg;
      case (state_reg)
         S_READ, S_GAP: mem_req_out.addr = act.src[23:0];
         S_WRITE: mem_req_out.addr = act.dst[23:0];
         default: mem_req_out.addr = 24'h00_0000;
      endcase
      mem_req_out.rd = state_reg == S_READ;
      mem_req_out.wr = state_reg == S_WRITE;
   end

   // The fetch slot is a dummy when the queue already holds enough.
   assign fetch_out = state_reg == S_FETCH && !queue_full_in;

   // Accepting an interrupt-triggered start clears that source's flag.
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         irq_clear_out <= '0;
      else
      begin
         irq_clear_out <= '0;
         if (dma_request_out && ch_reg[pick].vec[VEC_W-1:0] != '0
             && 32'(ch_reg[pick].vec[VEC_W-1:0]) <= SOURCES)
            irq_clear_out[VEC_W'(ch_reg[pick].vec[VEC_W-1:0]
                          - VEC_W'(1))] <= 1'b1;
      end
   end

   // End interrupt is a pulse; the controller ranks it by its own level.
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         transfer_end_interrupt_out <= '0;
      else
      begin
         transfer_end_interrupt_out <= '0;
         if (state_reg == S_DONE && cnt_next == RST_CNT)
            transfer_end_interrupt_out[act_reg] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: one write and one read outstanding.
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = s_axi_awready;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wmask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
   end

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a < 8'(CHANNELS) * CH_STRIDE && a[4:0] <= OFF_VEC[4:0])
               || a == OFF_SOFT || a == OFF_BURST || a == OFF_STATUS;
   endfunction

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(s_axi_awaddr) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Channel registers: engine updates at done, then software writes win.
   generate
      for (genvar c = 0; c < CHANNELS; c++)
      begin : g_regs
         logic sel, done_here;
         assign sel = wr_go && s_axi_awaddr[7:5] == 3'(c)
                      && s_axi_awaddr < 8'(CHANNELS) * CH_STRIDE;
         assign done_here = state_reg == S_DONE && act_reg == 2'(c);
         always_ff @(posedge clock_in or posedge rst_in)
         begin
            if (rst_in)
               ch_reg[c] <= '{RST_ADDR, RST_ADDR, RST_CNT, RST_BYTE, RST_BYTE};
            else
            begin
               if (done_here)
               begin
                  ch_reg[c].src <= src_next;
                  ch_reg[c].dst <= dst_next;
                  ch_reg[c].cnt <= cnt_next;
                  if (cnt_next == RST_CNT)
                     ch_reg[c].vec <= RST_BYTE;
               end
               if (sel)
                  case ({3'h0, s_axi_awaddr[4:0]})
                     OFF_SRC: ch_reg[c].src <= (ch_reg[c].src & ~wmask)
                                            | (s_axi_wdata & wmask);
                     OFF_DST: ch_reg[c].dst <= (ch_reg[c].dst & ~wmask)
                                            | (s_axi_wdata & wmask);
                     OFF_CNT: ch_reg[c].cnt <= (ch_reg[c].cnt & ~wmask[15:0])
                                            | (s_axi_wdata[15:0] & wmask[15:0]);
                     OFF_MODE:
                        if (s_axi_wstrb[0])
                           ch_reg[c].mode <= {3'h0, s_axi_wdata[4:0]};
                     OFF_VEC:
                        if (s_axi_wstrb[0])
                           ch_reg[c].vec <= s_axi_wdata[7:0];
                     default: ;
                  endcase
            end
         end
      end
   endgenerate

   // A software set in the clearing cycle wins over the clear.
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         software_start_register_reg <= '0;
      else
      begin
         if (state_reg == S_DONE && !continue_burst)
            software_start_register_reg[act_reg] <= 1'b0;
         if (wr_go && s_axi_awaddr == OFF_SOFT && s_axi_wstrb[0])
            for (int c = 0; c < CHANNELS; c++)
               if (s_axi_wdata[c])
                  software_start_register_reg[c] <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         burst_select_register_reg <= '0;
      else if (wr_go && s_axi_awaddr == OFF_BURST && s_axi_wstrb[0])
         burst_select_register_reg <= s_axi_wdata[CHANNELS-1:0];
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         s_axi_rdata <= 32'h0000_0000;
         if (s_axi_araddr < 8'(CHANNELS) * CH_STRIDE)
            case ({3'h0, s_axi_araddr[4:0]})
               OFF_SRC: s_axi_rdata <= ch_reg[s_axi_araddr[6:5]].src;
               OFF_DST: s_axi_rdata <= ch_reg[s_axi_araddr[6:5]].dst;
               OFF_CNT: s_axi_rdata <= {16'h0000, ch_reg[s_axi_araddr[6:5]].cnt};
               OFF_MODE: s_axi_rdata <= {24'h00_0000,
                                         ch_reg[s_axi_araddr[6:5]].mode};
               OFF_VEC: s_axi_rdata <= {24'h00_0000,
                                        ch_reg[s_axi_araddr[6:5]].vec};
               default: ;
            endcase
         else if (s_axi_araddr == OFF_SOFT)
            s_axi_rdata <= {28'h000_0000, software_start_register_reg};
         else if (s_axi_araddr == OFF_BURST)
            s_axi_rdata <= {28'h000_0000, burst_select_register_reg};
         else if (s_axi_araddr == OFF_STATUS)
            s_axi_rdata <= {23'h00_0000, state_reg, act_reg, pend};
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   a_level_six: assert property (dma_request_out |-> dma_level_out == 3'h6)
      else $error("service level is not six");
   a_mask_seven: assert property (cpu_interrupt_mask_level_in == 3'h7
      && state_reg == S_IDLE |=> state_reg == S_IDLE)
      else $error("service started at mask level seven");
   a_halt_hold: assert property (cpu_halted_in && state_reg == S_IDLE
      |=> state_reg == S_IDLE)
      else $error("service started while halted");
   a_lowest_chan: assert property (dma_request_out && pend[0]
      |=> act_reg == 2'h0 && state_reg == S_FETCH)
      else $error("channel zero not chosen first");
   a_flag_clear: assert property (dma_request_out && ch_reg[pick].vec == 8'h05
      |=> irq_clear_out[4])
      else $error("source flag not cleared on accept");
   a_count_dec: assert property (state_reg == S_DONE
      |=> ch_reg[$past(act_reg)].cnt == $past(act.cnt) - 16'h0001)
      else $error("count not decremented");
   a_end_irq: assert property (state_reg == S_DONE && act.cnt == 16'h0001
      |=> transfer_end_interrupt_out[$past(act_reg)]
          && ch_reg[$past(act_reg)].vec == 8'h00)
      else $error("end interrupt or vector clear missing");
   a_no_end_irq: assert property (state_reg == S_DONE && act.cnt != 16'h0001
      |=> transfer_end_interrupt_out == '0)
      else $error("spurious end interrupt");
   a_fetch_len: assert property ($rose(state_reg == S_FETCH)
      |-> (state_reg == S_FETCH) [*3] ##1 state_reg != S_FETCH)
      else $error("fetch phase not three states");
   a_soft_clr: assert property (state_reg == S_DONE && !continue_burst
      && !(wr_go && s_axi_awaddr == OFF_SOFT)
      |=> !software_start_register_reg[$past(act_reg)])
      else $error("software request bit not cleared");

   c_irq_start: cover property (irq_clear_out != '0);
   c_burst: cover property (state_reg == S_DONE && continue_burst);
   c_stretch: cover property (state_reg == S_READ && stretch);
   c_end: cover property (transfer_end_interrupt_out != '0);
endmodule
`default_nettype wire

// >>> micro_dma_pkg.sv
// Package for the interrupt-triggered micro DMA engine.
// Assumes one 200 MHz clock; all engine states take one clock each.
package micro_dma_pkg;

   localparam int CHANNELS = 4;
   localparam int SOURCES = 30;
   localparam int VEC_W = 5;
   localparam logic [2:0] DMA_LEVEL = 3'h6;
   localparam logic [2:0] MASK_BLOCK = 3'h7;

   // Register byte offsets; per-channel block at CH_STRIDE.
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [7:0] OFF_SRC = 8'h00;
   localparam logic [7:0] OFF_DST = 8'h04;
   localparam logic [7:0] OFF_CNT = 8'h08;
   localparam logic [7:0] OFF_MODE = 8'h0C;
   localparam logic [7:0] OFF_VEC = 8'h10;
   localparam logic [7:0] OFF_SOFT = 8'h80;
   localparam logic [7:0] OFF_BURST = 8'h84;
   localparam logic [7:0] OFF_STATUS = 8'h88;

   // Mode byte fields.
   localparam int MODE_LSB = 2;
   localparam int SIZE_LSB = 0;
   localparam logic [2:0] M_DST_INC = 3'h0;
   localparam logic [2:0] M_DST_DEC = 3'h1;
   localparam logic [2:0] M_SRC_INC = 3'h2;
   localparam logic [2:0] M_SRC_DEC = 3'h3;
   localparam logic [2:0] M_FIXED = 3'h4;
   localparam logic [2:0] M_COUNTER = 3'h5;
   localparam logic [1:0] SZ_BYTE = 2'h0;

   // Reset values.
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // Sequencer state counts.
   localparam logic [2:0] ST_FETCH = 3'h3;
   localparam logic [2:0] ST_BUS = 3'h2;
   localparam logic [2:0] ST_STRETCH = 3'h2;
   localparam logic [2:0] ST_GAP = 3'h1;
   localparam logic [2:0] ST_COUNTER = 3'h2;

   typedef struct packed {
      logic [31:0] src;
      logic [31:0] dst;
      logic [15:0] cnt;
      logic [7:0] mode;
      logic [7:0] vec;
   } chan_regs_t;

   typedef struct packed {
      logic [23:0] addr;
      logic rd;
      logic wr;
      logic [1:0] size;
      logic [31:0] wdata;
   } mem_req_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_FETCH = 3'b001,
      S_READ = 3'b010,
      S_GAP = 3'b011,
      S_WRITE = 3'b100,
      S_COUNT = 3'b101,
      S_DONE = 3'b110
   } seq_state_t;

endpackage

// >>> micro_dma_tb.sv
// Self-checking bench for the micro DMA engine, one task per scenario.
// Assumes the partner model answers the memory bus and holds source flags.
`timescale 1ns/100ps
`default_nettype none
module micro_dma_tb;
   import micro_dma_pkg::*;
   logic clock_in = 1'b0, rst_in = 1'b1, hlt = 1'b0, awv = 1'b0, wv = 1'b0;
   logic bry = 1'b0, arv = 1'b0, rry = 1'b0, awr, bv, arr, rv;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wdt = 32'h0, rdt, mrd, wd, rd;
   logic [1:0] br, rr, resp;
   logic [2:0] lvl, msk = 3'h0;
   logic [3:0] te, te_last = 4'h0;
   logic [SOURCES-1:0] flags, clr, raise = '0;
   logic [23:0] waddr;
   logic [15:0] nw;
   mem_req_t req;
   int fail_count = 0, total_checks = 0, cyc = 0;
   always #2.5 clock_in = ~clock_in;
   micro_dma micro_dma_inst (
      .clock_in(clock_in), .rst_in(rst_in), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdt),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .irq_flag_in(flags), .cpu_halted_in(hlt),
      .cpu_interrupt_mask_level_in(msk), .queue_full_in(1'b0),
      .irq_clear_out(clr), .transfer_end_interrupt_out(te),
      .dma_request_out(), .dma_level_out(lvl), .mem_rdata_in(mrd),
      .mem_area8_in(1'b0), .mem_req_out(req), .fetch_out());
   dma_partner dma_partner_inst (
      .clock_in(clock_in), .rst_in(rst_in), .req_in(req), .clr_in(clr),
      .raise_in(raise), .rdata_out(mrd), .flag_out(flags),
      .waddr_out(waddr), .wdata_out(wd), .writes_out(nw));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
         $display("Error %s expected %h seen %h", n, e, s);
      fail_count += int'(s !== e);
   endtask
   // Writes offer address and data together; reads share the same wait.
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      {awa, ara, wdt} <= {a, a, d};
      {awv, wv, arv} <= {wr, wr, !wr};
      do @(posedge clock_in); while ((wr ? awr : arr) !== 1'b1);
      {awv, wv, arv} <= 3'b000;
      {bry, rry} <= {wr, !wr};
      do @(posedge clock_in); while ((wr ? bv : rv) !== 1'b1);
      {resp, rd} = wr ? {br, 32'h0} : {rr, rdt};
      {bry, rry} <= 2'b00;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(n, rd, e);
   endtask
   task automatic kick();
      raise <= 30'h10;
      @(posedge clock_in);
      raise <= '0;
      repeat (30) @(posedge clock_in);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clock_in)
   begin
      cyc++;
      if (|te)
         te_last = te;
      fail_count += int'(cyc == 5000);
      if (cyc == 5000)
         end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic t_soft();
      chk("level", 32'(lvl), 32'h6);
      w(8'h9C, 32'h1);
      chk("bresp", 32'(resp), 32'h2);
      w(8'h00, 32'hFF00_0100);
      w(8'h04, 32'h200);
      w(8'h08, 32'h2);
      w(8'h0C, 32'hE1);
      w(OFF_SOFT, 32'h1);
      while (nw !== 16'h1) @(posedge clock_in);
      chk("write", {waddr[15:0], wd[15:0]}, 32'h0200_0100);
      rc("dst", 8'h04, 32'h202);
      rc("mode", 8'h0C, 32'h1);
      rc("count", 8'h08, 32'h1);
      rc("soft", OFF_SOFT, 32'h0);
      chk("no end", 32'(te_last), 32'h0);
      $display("soft start done");
   endtask
   task automatic t_irq();
      w(8'h20, 32'h10);
      w(8'h28, 32'h1);
      w(8'h2C, 32'h08);
      w(8'h30, 32'h5);
      msk <= 3'h7;
      kick();
      chk("masked", 32'(nw), 32'h1);
      {msk, hlt} <= 4'h1;
      kick();
      chk("halted", 32'(nw), 32'h1);
      hlt <= 1'b0;
      while (nw !== 16'h2) @(posedge clock_in);
      rc("vector", 8'h30, 32'h0);
      chk("end", 32'(te_last), 32'h2);
      chk("flag", 32'(flags), 32'h0);
      rc("src", 8'h20, 32'h11);
      kick();
      chk("plain", 32'({flags[4], nw}), 32'h1_0002);
      $display("irq start done");
   endtask
   task automatic t_prio();
      w(8'h28, 32'h5);
      msk <= 3'h7;
      w(OFF_SOFT, 32'h2);
      w(OFF_SOFT, 32'h1);
      w(OFF_SOFT, 32'h0);
      rc("pending", OFF_SOFT, 32'h3);
      msk <= 3'h0;
      while (nw !== 16'h3) @(posedge clock_in);
      chk("first", 32'(waddr), 32'h202);
      while (nw !== 16'h4) @(posedge clock_in);
      chk("second", 32'(waddr), 32'h0);
      $display("priority done");
   endtask
   task automatic t_burst();
      w(8'h48, 32'h3);
      w(8'h4C, 32'h14);
      w(OFF_BURST, 32'h4);
      w(OFF_SOFT, 32'h4);
      while (te_last !== 4'h4) @(posedge clock_in);
      rc("burst src", 8'h40, 32'h3);
      rc("burst count", 8'h48, 32'h0);
      chk("no write", 32'(nw), 32'h4);
      w(8'h6C, 32'h10);
      w(OFF_SOFT, 32'h8);
      while (nw !== 16'h5) @(posedge clock_in);
      rc("wrap", 8'h68, 32'hFFFF);
      $display("burst done");
   endtask
   initial
   begin
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      t_soft();
      t_irq();
      t_prio();
      t_burst();
      end_of_test();
   end
endmodule
`default_nettype wire
